/* rtl/serial_port_pkg.sv */
// Constants and types shared by the serial port with address match
package serial_port_pkg;
   localparam int ADDR_W = 12;
   localparam int CNT_W  = 7;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] SERIAL_CONTROL_IDX = 8'h98;
   localparam logic [7:0] SERIAL_BUFFER_IDX  = 8'h99;
   localparam logic [7:0] SLAVE_ADDRESS_IDX  = 8'hA9;
   localparam logic [7:0] SLAVE_MASK_IDX     = 8'hB9;
   localparam logic [7:0] PORT_CONFIG_IDX    = 8'hC0;
   localparam logic [7:0] IRQ_STATUS_IDX     = 8'hC1;
   localparam logic [7:0] IRQ_MASK_IDX       = 8'hC2;

   // Reset values
   localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
   localparam logic [7:0] SLAVE_ADDRESS_RST  = 8'h00;
   localparam logic [7:0] SLAVE_MASK_RST     = 8'h00;
   localparam logic [5:0] PORT_CONFIG_RST    = 6'h00;
   localparam logic [2:0] IRQ_MASK_RST       = 3'h0;

   // Interrupt status and mask bit positions
   localparam int IRQ_TX_DONE = 0;
   localparam int IRQ_RX_DONE = 1;
   localparam int IRQ_FRAME   = 2;
   localparam int IRQ_W       = 3;

   // Field positions in the serial control register
   localparam int SC_MODE_HI = 7;

   // Bit times in clocks or in timer overflow ticks
   localparam logic [CNT_W-1:0] MODE0_SLOW_CLKS  = 7'h0C;
   localparam logic [CNT_W-1:0] MODE0_FAST_CLKS  = 7'h04;
   localparam logic [CNT_W-1:0] MODE2_SLOW_CLKS  = 7'h40;
   localparam logic [CNT_W-1:0] MODE2_FAST_CLKS  = 7'h20;
   localparam int               OVERSAMPLE_TICKS = 16;

   // Index of the last bit of a frame, counted from zero
   localparam logic [3:0] LAST_BIT_SYNC   = 4'h7;
   localparam logic [3:0] LAST_BIT_ASYNC10 = 4'h9;
   localparam logic [3:0] LAST_BIT_ASYNC11 = 4'hA;

   typedef enum logic [1:0] {
      MODE_SYNC,
      MODE_ASYNC10,
      MODE_ASYNC11_FIXED,
      MODE_ASYNC11_VAR
   } serial_mode_t;

   typedef struct packed {
      logic mode_hi;
      logic mode_lo;
      logic multiproc_enable;
      logic rx_enable;
      logic tx_ninth_bit;
      logic rx_ninth_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } serial_control_t;

   typedef struct packed {
      logic tx_clk_src;
      logic rx_clk_src;
      logic global_irq_enable;
      logic serial_irq_enable;
      logic baud_double;
      logic frame_error_select;
   } port_config_t;
endpackage : serial_port_pkg

/* rtl/serial_port_with_address_match.sv */
// Serial port with synchronous and asynchronous modes and slave address match
//
// Functional notes
// - Control bit 7 is mode-high or framing error, chosen by frame_error_select.
// - Framing error flag sets on a bad stop bit, stays until software clears.
// - Modes: 0 sync 8 bits, 1 async 10, 2 async 11 fixed, 3 async 11 variable.
// - Modes 2/3 with multiproc_enable: no receive flag when ninth bit is zero.
// - Mode 1 with multiproc_enable: no receive flag without valid stop bit.
// - Mode 0: multiproc_enable selects 4 or 12 clocks per bit.
// - Reception starts only while rx_enable is one.
// - Modes 2/3 send tx_ninth_bit as ninth bit, unaltered by hardware.
// - rx_ninth_bit holds ninth bit (modes 2/3), stop bit (mode 1, no multiproc).
// - Transmit flag sets after bit 8 in mode 0, at stop start otherwise.
// - Receive flag sets after bit 8 in mode 0, mid stop bit otherwise.
// - Buffer reads return received byte; writes load the transmit buffer only when transmitter idle.
// - Slave address register holds the address matched in multiproc reception.
// - Interrupt reaches core only with serial and global enables both set.
// - Transmit line drives txd in modes 1-3, rxd in mode 0; receive data taken from rxd.
// - Mask bits select compared address bits; all-zero mask matches everything.
// - Modes 1/3 rates from timer 1 overflow, or timer 2 when source bit set.
`timescale 1ns/1ps
`default_nettype none
module serial_port_with_address_match #(
   parameter int OVS_TICKS = serial_port_pkg::OVERSAMPLE_TICKS
) (
   input  wire logic                                ref_clk,
   input  wire logic                                reset_n,
   input  wire logic                                clk_en,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [serial_port_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                         pwdata,
   output logic      [31:0]                         prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic                                timer1_ovf,
   input  wire logic                                timer2_ovf,
   input  wire logic                                rxd_in,
   output logic                                     rxd_out,
   output logic                                     rxd_oe_n,
   output logic                                     txd,
   output logic                                     irq
);
   import serial_port_pkg::*;

   if (OVS_TICKS < 2 || OVS_TICKS > 127) begin : g_check
      $error("OVS_TICKS must lie between 2 and 127");
   end

   localparam logic [CNT_W-1:0] OVS_LEN = CNT_W'(OVS_TICKS);

   typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} rx_state_t;

   serial_control_t  serial_control_q;
   port_config_t     cfg_q;
   serial_mode_t     mode;
   rx_state_t        rx_state_q;
   logic             fe_q;
   logic [7:0]       rx_buf_q;
   logic [7:0]       slave_addr_q;
   logic [7:0]       slave_mask_q;
   logic [IRQ_W-1:0] irq_status_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_events;
   logic [31:0]      prdata_q;
   logic [31:0]      rd_mux;
   logic [7:0]       reg_idx;
   logic             mapped;
   logic             acc_wr;
   logic             serial_control_wr;
   logic             buf_wr;
   logic             is11;
   logic [CNT_W-1:0] bit_len;
   logic [3:0]       frame_last;
   logic             tx_unit;
   logic             rx_unit;
   logic             tx_active_q;
   logic [10:0]      tx_sr_q;
   logic [3:0]       tx_idx_q;
   logic [CNT_W-1:0] tx_cnt_q;
   logic             tx_bit_end;
   logic             tx_start;
   logic             tx_done_evt;
   logic [3:0]       rx_idx_q;
   logic [CNT_W-1:0] rx_cnt_q;
   logic [8:0]       rx_sr_q;
   logic             rx_bit_end;
   logic             rx_mid;
   logic             rx_async_go;
   logic             rx_sync_go;
   logic             rx_stop_pt;
   logic             rx_sync_done;
   logic             rx_accept;
   logic             fe_evt;
   logic             addr_match;
   logic [7:0]       rx_data;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // APB decode
   assign reg_idx = paddr[9:2];
   assign pready  = clk_en;
   always_comb begin
      mapped = 1'b0;
      if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0) begin
         unique case (reg_idx)
            SERIAL_CONTROL_IDX, SERIAL_BUFFER_IDX, SLAVE_ADDRESS_IDX, SLAVE_MASK_IDX,
            PORT_CONFIG_IDX, IRQ_STATUS_IDX, IRQ_MASK_IDX: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   end
   assign pslverr = psel && penable && !mapped;
   assign acc_wr  = psel && penable && pwrite && clk_en && mapped;
   assign serial_control_wr = acc_wr && reg_idx == SERIAL_CONTROL_IDX;
   assign buf_wr  = acc_wr && reg_idx == SERIAL_BUFFER_IDX;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (mapped) begin
         unique case (reg_idx)
            SERIAL_CONTROL_IDX: begin
               rd_mux[7:0]        = serial_control_q;
               rd_mux[SC_MODE_HI] = cfg_q.frame_error_select ? fe_q : serial_control_q.mode_hi;
            end
            SERIAL_BUFFER_IDX: rd_mux[7:0] = rx_buf_q;
            SLAVE_ADDRESS_IDX: rd_mux[7:0] = slave_addr_q;
            SLAVE_MASK_IDX:    rd_mux[7:0] = slave_mask_q;
            PORT_CONFIG_IDX:   rd_mux[5:0] = cfg_q;
            IRQ_STATUS_IDX:    rd_mux[IRQ_W-1:0] = irq_status_q;
            IRQ_MASK_IDX:      rd_mux[IRQ_W-1:0] = irq_mask_q;
            default:           rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // Read data is captured on every selected cycle with clk_en set so it is ready at access
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_q <= 32'h0000_0000;
      end else if (clk_en && psel) begin
         prdata_q <= rd_mux;
      end
   end
   assign prdata = prdata_q;

   // ==========================================================
   // Software registers
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slave_addr_q <= SLAVE_ADDRESS_RST;
         slave_mask_q <= SLAVE_MASK_RST;
         cfg_q        <= PORT_CONFIG_RST;
         irq_mask_q   <= IRQ_MASK_RST;
      end else if (acc_wr) begin
         if (reg_idx == SLAVE_ADDRESS_IDX) slave_addr_q <= pwdata[7:0];
         if (reg_idx == SLAVE_MASK_IDX)    slave_mask_q <= pwdata[7:0];
         if (reg_idx == PORT_CONFIG_IDX)   cfg_q        <= pwdata[5:0];
         if (reg_idx == IRQ_MASK_IDX)      irq_mask_q   <= pwdata[IRQ_W-1:0];
      end
   end

   // Serial control: hardware sets win over a software clear
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_control_q <= SERIAL_CONTROL_RST;
         fe_q   <= 1'b0;
      end else if (clk_en) begin
         if (serial_control_wr) begin
            serial_control_q.mode_lo          <= pwdata[6];
            serial_control_q.multiproc_enable <= pwdata[5];
            serial_control_q.rx_enable        <= pwdata[4];
            serial_control_q.tx_ninth_bit     <= pwdata[3];
            if (!cfg_q.frame_error_select) serial_control_q.mode_hi <= pwdata[SC_MODE_HI];
         end
         if (fe_evt) fe_q <= 1'b1;
         else if (serial_control_wr && cfg_q.frame_error_select) fe_q <= pwdata[SC_MODE_HI];
         if (rx_accept) serial_control_q.rx_ninth_bit <= is11 ? rx_sr_q[8] : rxd_in;
         else if (serial_control_wr) serial_control_q.rx_ninth_bit <= pwdata[2];
         if (tx_done_evt) serial_control_q.tx_done_flag <= 1'b1;
         else if (serial_control_wr) serial_control_q.tx_done_flag <= pwdata[1];
         if (rx_accept) serial_control_q.rx_done_flag <= 1'b1;
         else if (serial_control_wr) serial_control_q.rx_done_flag <= pwdata[0];
      end
   end

   // ==========================================================
   // Mode and bit timing
   assign mode = serial_mode_t'({serial_control_q.mode_hi, serial_control_q.mode_lo});
   assign is11 = serial_control_q.mode_hi;

   always_comb begin
      unique case (mode)
         MODE_SYNC: begin
            bit_len    = serial_control_q.multiproc_enable ? MODE0_FAST_CLKS : MODE0_SLOW_CLKS;
            frame_last = LAST_BIT_SYNC;
            tx_unit    = 1'b1;
            rx_unit    = 1'b1;
         end
         MODE_ASYNC11_FIXED: begin
            bit_len    = cfg_q.baud_double ? MODE2_FAST_CLKS : MODE2_SLOW_CLKS;
            frame_last = LAST_BIT_ASYNC11;
            tx_unit    = 1'b1;
            rx_unit    = 1'b1;
         end
         MODE_ASYNC10, MODE_ASYNC11_VAR: begin
            bit_len    = OVS_LEN;
            frame_last = is11 ? LAST_BIT_ASYNC11 : LAST_BIT_ASYNC10;
            tx_unit    = cfg_q.tx_clk_src ? timer2_ovf : timer1_ovf;
            rx_unit    = cfg_q.rx_clk_src ? timer2_ovf : timer1_ovf;
         end
      endcase
   end

   // ==========================================================
   // Transmitter
   assign tx_start    = buf_wr && !tx_active_q;
   assign tx_bit_end  = tx_cnt_q >= bit_len - 7'h01;
   assign tx_done_evt = clk_en && tx_active_q && tx_unit && tx_bit_end &&
                        tx_idx_q == (mode == MODE_SYNC ? LAST_BIT_SYNC : frame_last - 4'h1);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_active_q <= 1'b0;
         tx_sr_q     <= 11'h7FF;
         tx_idx_q    <= 4'h0;
         tx_cnt_q    <= '0;
      end else if (clk_en) begin
         if (tx_start) begin
            tx_active_q <= 1'b1;
            tx_idx_q    <= 4'h0;
            tx_cnt_q    <= '0;
            if (mode == MODE_SYNC) tx_sr_q <= {3'h7, pwdata[7:0]};
            else tx_sr_q <= {1'b1, is11 ? serial_control_q.tx_ninth_bit : 1'b1, pwdata[7:0], 1'b0};
         end else if (tx_active_q && tx_unit) begin
            if (tx_bit_end) begin
               tx_cnt_q <= '0;
               tx_sr_q  <= {1'b1, tx_sr_q[10:1]};
               tx_idx_q <= tx_idx_q + 4'h1;
               if (tx_idx_q == frame_last) tx_active_q <= 1'b0;
            end else begin
               tx_cnt_q <= tx_cnt_q + 7'h01;
            end
         end
      end
   end

   // ==========================================================
   // Receiver
   assign rx_bit_end   = rx_cnt_q >= bit_len - 7'h01;
   assign rx_mid       = rx_cnt_q == (bit_len >> 1) - 7'h01;
   assign rx_async_go  = mode != MODE_SYNC && serial_control_q.rx_enable && !rxd_in;
   assign rx_sync_go   = mode == MODE_SYNC && serial_control_q.rx_enable && !serial_control_q.rx_done_flag &&
                         !tx_active_q && !buf_wr;
   assign rx_stop_pt   = clk_en && rx_state_q == RX_ASYNC && rx_unit && rx_mid &&
                         rx_idx_q == frame_last;
   assign rx_sync_done = clk_en && rx_state_q == RX_SYNC && rx_bit_end &&
                         rx_idx_q == LAST_BIT_SYNC;
   assign addr_match   = ((rx_data ^ slave_addr_q) & slave_mask_q) == 8'h00;
   assign fe_evt       = rx_stop_pt && !rxd_in;

   always_comb begin
      if (rx_state_q == RX_SYNC) rx_data = {rxd_in, rx_sr_q[8:2]};
      else if (is11) rx_data = rx_sr_q[7:0];
      else rx_data = rx_sr_q[8:1];
   end

   always_comb begin
      rx_accept = rx_sync_done;
      if (rx_stop_pt && !serial_control_q.rx_done_flag) begin
         if (is11) rx_accept = !serial_control_q.multiproc_enable || (rx_sr_q[8] && addr_match);
         else rx_accept = !serial_control_q.multiproc_enable || rxd_in;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_buf_q <= 8'h00;
      end else if (rx_accept) begin
         rx_buf_q <= rx_data;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q   <= '0;
         rx_idx_q   <= 4'h0;
         rx_sr_q    <= 9'h000;
      end else if (clk_en) begin
         unique case (rx_state_q)
            RX_IDLE: begin
               rx_cnt_q <= '0;
               rx_idx_q <= 4'h0;
               if (rx_async_go) rx_state_q <= RX_ASYNC;
               else if (rx_sync_go) rx_state_q <= RX_SYNC;
            end
            RX_ASYNC: begin
               if (rx_unit) begin
                  rx_cnt_q <= rx_bit_end ? '0 : rx_cnt_q + 7'h01;
                  if (rx_bit_end) rx_idx_q <= rx_idx_q + 4'h1;
                  if (rx_mid) begin
                     // A start bit that is high again at mid-bit was a glitch
                     if (rx_idx_q == 4'h0 && rxd_in) rx_state_q <= RX_IDLE;
                     else if (rx_idx_q == frame_last) rx_state_q <= RX_IDLE;
                     else if (rx_idx_q != 4'h0) rx_sr_q <= {rxd_in, rx_sr_q[8:1]};
                  end
               end
            end
            RX_SYNC: begin
               rx_cnt_q <= rx_bit_end ? '0 : rx_cnt_q + 7'h01;
               if (rx_bit_end) begin
                  rx_sr_q  <= {rxd_in, rx_sr_q[8:1]};
                  rx_idx_q <= rx_idx_q + 4'h1;
                  if (rx_idx_q == LAST_BIT_SYNC) rx_state_q <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Pins: mode 0 shifts data on rxd and the clock out on txd
   always_comb begin
      txd = 1'b1;
      if (mode == MODE_SYNC) begin
         if (tx_active_q) txd = tx_cnt_q >= (bit_len >> 1);
         else if (rx_state_q == RX_SYNC) txd = rx_cnt_q >= (bit_len >> 1);
      end else if (tx_active_q) begin
         txd = tx_sr_q[0];
      end
   end
   assign rxd_out  = tx_sr_q[0];
   assign rxd_oe_n = !(tx_active_q && mode == MODE_SYNC);

   // ==========================================================
   // Interrupts
   always_comb begin
      irq_events              = '0;
      irq_events[IRQ_TX_DONE] = tx_done_evt;
      irq_events[IRQ_RX_DONE] = rx_accept;
      irq_events[IRQ_FRAME]   = fe_evt;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_q <= '0;
      end else if (clk_en) begin
         if (acc_wr && reg_idx == IRQ_STATUS_IDX) irq_status_q <= (irq_status_q & ~pwdata[IRQ_W-1:0]) | irq_events;
         else irq_status_q <= irq_status_q | irq_events;
      end
   end
   assign irq = cfg_q.serial_irq_enable && cfg_q.global_irq_enable && |(irq_status_q & irq_mask_q);

   // ==========================================================
   // Checks
   irq_gate_a: assert property (irq |-> cfg_q.serial_irq_enable && cfg_q.global_irq_enable)
      else $error("interrupt raised without both enables");
   fe_sticky_a: assert property ($fell(fe_q) |-> $past(serial_control_wr && cfg_q.frame_error_select && !pwdata[7]))
      else $error("framing error flag cleared without software write");
   ninth_gate_a: assert property ($rose(serial_control_q.rx_done_flag) && !$past(serial_control_wr) && $past(is11 && serial_control_q.multiproc_enable)
      |-> serial_control_q.rx_ninth_bit)
      else $error("receive flag raised with ninth bit zero");
   stop_gate_a: assert property ($rose(serial_control_q.rx_done_flag) && !$past(serial_control_wr)
      && $past(mode == MODE_ASYNC10 && serial_control_q.multiproc_enable) |-> $past(rxd_in))
      else $error("receive flag raised without valid stop bit");
   rx_enable_a: assert property ($rose(rx_state_q != RX_IDLE) |-> $past(serial_control_q.rx_enable))
      else $error("reception started while disabled");
   ninth_sent_a: assert property ($rose(tx_active_q) && $past(is11) |-> tx_sr_q[9] == $past(serial_control_q.tx_ninth_bit))
      else $error("ninth transmit bit differs from software value");
   tx_flag_a: assert property ($rose(serial_control_q.tx_done_flag) && !$past(serial_control_wr) |-> $past(tx_active_q))
      else $error("transmit flag set outside a frame");
   buf_read_a: assert property (psel && penable && !pwrite && mapped && reg_idx == SERIAL_BUFFER_IDX
      && $past(psel) && $past(clk_en) |-> prdata == {24'h000000, $past(rx_buf_q)})
      else $error("buffer read did not return received byte");
   txd_idle_a: assert property (!tx_active_q && rx_state_q != RX_SYNC |-> txd)
      else $error("transmit line not idle high");
   mask_zero_a: assert property (rx_stop_pt && slave_mask_q == 8'h00 && is11 && serial_control_q.multiproc_enable
      && rx_sr_q[8] && !serial_control_q.rx_done_flag |=> serial_control_q.rx_done_flag)
      else $error("all-zero mask did not match address");
   tx_start_a: assert property (tx_start |=> tx_active_q ##1 tx_active_q)
      else $error("buffer write did not start a frame");
   sync_start_a: assert property (clk_en && rx_state_q == RX_IDLE && !rx_async_go && rx_sync_go
      |=> rx_state_q == RX_SYNC)
      else $error("mode 0 reception did not start");
endmodule : serial_port_with_address_match
`default_nettype wire

/* bench/serial_node.sv */
// Remote serial node that drives and samples the asynchronous link
`timescale 1ns/1ps
`default_nettype none
module serial_node #(
   parameter int BIT_CLKS = 32
) (
   input  wire logic ref_clk,
   input  wire logic txd,
   output var  logic rxd
);
   // Idle line level of the link
   initial rxd = 1'b1;

   task automatic send(input logic [7:0] data, input logic ninth, input logic stop);
      logic [10:0] frame;
      frame = {stop, ninth, data, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge ref_clk);
         rxd <= frame[i];
         repeat (BIT_CLKS - 1) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      rxd <= 1'b1;
   endtask : send

   // Data and ninth bit sampled at mid bit
   task automatic recv(output logic [8:0] word);
      wait (txd === 1'b0);
      repeat (BIT_CLKS / 2) @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CLKS) @(posedge ref_clk);
         word[i] = txd;
      end
   endtask : recv
endmodule : serial_node
`default_nettype wire

/* bench/serial_port_with_address_match_test.sv */
// Self-checking bench for the serial port with address match
`timescale 1ns/1ps
`default_nettype none
module serial_port_with_address_match_test;
   import serial_port_pkg::*;
   logic              ref_clk, reset_n, clk_en, psel, penable, pwrite, timer1_ovf, timer2_ovf;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              pready, pslverr, rxd_out, rxd_oe_n, txd, irq, node_rxd, rxd_line, err;
   logic [8:0]        word;
   logic [7:0]        sh;
   time               t0;
   int                n_fail = 0;
   int                n_compared = 0;

   assign rxd_line = rxd_oe_n ? node_rxd : rxd_out;

   serial_port_with_address_match uut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .rxd_in(rxd_line),
      .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd), .irq(irq));
   serial_node node (.ref_clk(ref_clk), .txd(txd), .rxd(node_rxd));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         timer1_ovf <= 1'b0;
         timer2_ovf <= 1'b0;
      end else begin
         timer1_ovf <= ~timer1_ovf;
         timer2_ovf <= timer1_ovf;
      end
   end

   task automatic results;
      if (n_fail == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      apb(1'b1, idx, wd);
   endtask : wr

   task automatic rdm(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp, input string name);
      apb(1'b0, idx, 8'h00);
      chk(name, exp, rd & mask);
   endtask : rdm

   task automatic rx_case(input logic [7:0] ctl, input logic [7:0] data, input logic ninth, input logic [31:0] exp,
                          input string name);
      wr(SERIAL_CONTROL_IDX, ctl);
      node.send(data, ninth, 1'b1);
      repeat (4) @(posedge ref_clk);
      rdm(SERIAL_CONTROL_IDX, 32'h1, exp, name);
   endtask : rx_case

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      results();
   end

   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      rdm(SERIAL_CONTROL_IDX, 32'hFFFFFFFF, 32'h0, "control reset");
      rdm(SLAVE_ADDRESS_IDX, 32'hFFFFFFFF, 32'h0, "address reset");
      rdm(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped read");
      chk("unmapped error", 32'h1, {31'h0, err});
      wr(PORT_CONFIG_IDX, 8'h0E);
      wr(IRQ_MASK_IDX, 8'h07);
      wr(SERIAL_CONTROL_IDX, 8'h88);
      wr(SERIAL_BUFFER_IDX, 8'hA5);
      node.recv(word);
      chk("tx frame", 32'h1A5, {23'h0, word});
      chk("irq before stop", 32'h0, {31'h0, irq});
      repeat (20) @(posedge ref_clk);
      chk("irq at stop", 32'h1, {31'h0, irq});
      rdm(SERIAL_CONTROL_IDX, 32'h2, 32'h2, "tx flag");
      wr(PORT_CONFIG_IDX, 8'h06);
      @(posedge ref_clk);
      chk("irq gated", 32'h0, {31'h0, irq});
      wr(SLAVE_ADDRESS_IDX, 8'h5A);
      wr(SLAVE_MASK_IDX, 8'hF0);
      rx_case(8'hB0, 8'h5A, 1'b0, 32'h0, "ninth zero");
      rx_case(8'hB0, 8'h53, 1'b1, 32'h1, "address match");
      rdm(SERIAL_BUFFER_IDX, 32'hFFFFFFFF, 32'h53, "rx data");
      rdm(SERIAL_CONTROL_IDX, 32'h4, 32'h4, "rx ninth");
      rx_case(8'hB0, 8'hA3, 1'b1, 32'h0, "address miss");
      wr(SLAVE_MASK_IDX, 8'h00);
      rx_case(8'hB0, 8'hA3, 1'b1, 32'h1, "zero mask");
      rx_case(8'h80, 8'h11, 1'b1, 32'h0, "rx disabled");
      wr(SERIAL_CONTROL_IDX, 8'h90);
      node.send(8'h22, 1'b1, 1'b0);
      repeat (4) @(posedge ref_clk);
      wr(PORT_CONFIG_IDX, 8'h0F);
      rdm(SERIAL_CONTROL_IDX, 32'h80, 32'h80, "framing flag");
      rdm(IRQ_STATUS_IDX, 32'h4, 32'h4, "framing status");
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(IRQ_MASK_IDX, 8'h00);
      @(posedge ref_clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(IRQ_STATUS_IDX, 8'h07);
      rdm(IRQ_STATUS_IDX, 32'h7, 32'h0, "status cleared");
      wr(PORT_CONFIG_IDX, 8'h2C);
      wr(SERIAL_CONTROL_IDX, 8'hC0);
      wr(SERIAL_BUFFER_IDX, 8'h3C);
      node.recv(word);
      chk("mode3 frame", 32'h03C, {23'h0, word});
      repeat (60) @(posedge ref_clk);
      wr(SERIAL_CONTROL_IDX, 8'h20);
      wr(SERIAL_BUFFER_IDX, 8'h6C);
      for (int i = 0; i < 8; i++) begin
         @(posedge txd);
         if (i == 0) t0 = $time;
         sh[i] = rxd_line;
      end
      chk("mode0 data", 32'h6C, {24'h0, sh});
      chk("mode0 bit time", 32'h70, 32'($time - t0));
      repeat (3) @(posedge ref_clk);
      chk("mode0 release", 32'h1, {31'h0, rxd_oe_n});
      rdm(SERIAL_CONTROL_IDX, 32'h2, 32'h2, "mode0 tx flag");
      wr(SERIAL_CONTROL_IDX, 8'h30);
      repeat (40) @(posedge ref_clk);
      rdm(SERIAL_CONTROL_IDX, 32'h1, 32'h1, "mode0 rx flag");
      rdm(SERIAL_BUFFER_IDX, 32'hFFFFFFFF, 32'hFF, "mode0 rx data");
      results();
   end
endmodule : serial_port_with_address_match_test
`default_nettype wire
